// [inc/bridge_ctrl_regs.svh]
`ifndef BRIDGE_CTRL_REGS_SVH
`define BRIDGE_CTRL_REGS_SVH

// register offsets (byte addresses, one aligned word each)
`define BDC_ADDR_CTRL       8'h00
`define BDC_ADDR_IRQ_STATUS 8'h04
`define BDC_ADDR_IRQ_ENABLE 8'h08
`define BDC_ADDR_IRQ_CLEAR  8'h0c

// driver field groups: low_a at bit 0, low_b at bit 8, high_a at bit 16
`define BDC_DRV_STRIDE      8
`define BDC_DRV_COUNT       3
`define BDC_LOW_COUNT       2

// field positions inside one driver group
`define BDC_FLD_POWER_EN    0
`define BDC_FLD_PWM_FOLLOW  1
`define BDC_FLD_SWITCH_ON   2
`define BDC_FLD_DIAG_SRC    3
`define BDC_FLD_DRAIN_SHORT 4
`define BDC_FLD_SUPPLY_ERR  5
`define BDC_FLD_OVERCURRENT 6
`define BDC_FLD_SHUT_SCOPE  7

// control register: reset value and software writable bits
`define BDC_CTRL_RESET      21'h010101
`define BDC_CTRL_WR_MASK    21'h0f8f8f

// interrupt status layout
`define BDC_IRQ_OC_LSB      0
`define BDC_IRQ_SUP_LSB     2
`define BDC_IRQ_DS_LSB      4
`define BDC_IRQ_RESET       7'h00

`endif

// [inc/bridge_ctrl_pkg.sv]
package bridge_ctrl_pkg;

    typedef logic [7:0]  addr_t;
    typedef logic [31:0] data_t;
    typedef logic [20:0] ctrl_t;
    typedef logic [6:0]  irq_t;

    // pins coming from the external fet monitors, all asynchronous to clk
    typedef struct packed {
        logic [2:0] pwmIn;                  // pwm inputs: high_a, low_b, low_a
        logic [2:0] drainShort;             // off-state drain-source short detect
        logic [1:0] overcurrent;            // low-side overcurrent detect
        logic [1:0] drainSupplyStatus;      // drain-source supply fault per low driver
        logic [1:0] chargePumpSupplyStatus; // charge pump supply fault per low driver
    } fet_monitor_s;

    // events that set sticky interrupt status bits
    typedef struct packed {
        logic [2:0] drainShort;
        logic [1:0] supplyError;
        logic [1:0] overcurrent;
    } irq_event_s;

endpackage

// [rtl/sync_flags.sv]
`timescale 1ns/1ps

// two-flop synchroniser for a bundle of asynchronous levels
module sync_flags #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] metaReg;

    // refuse a bundle that carries nothing
    if (WIDTH < 1) begin : gWidthCheck
        $error("sync_flags: WIDTH must be at least 1");
    end

    // first stage is read only by the second stage
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            metaReg <= '0;
            syncOut <= '0;
        end else begin
            metaReg <= asyncIn;
            syncOut <= metaReg;
        end
    end

endmodule // sync_flags

// [rtl/bridge_driver_control.sv]
`timescale 1ns/1ps
`include "bridge_ctrl_regs.svh"

module bridge_driver_control
    import bridge_ctrl_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire addr_t        busAddr,
    input  wire data_t        busWrData,
    input  wire logic         busWrite,
    input  wire logic         busRead,
    output data_t             busRdData,
    input  wire logic         resetClassThree,
    input  wire logic         otherBridgeShutdown,
    input  wire fet_monitor_s fetMonitor,
    output logic [2:0]        gateOn,
    output logic [2:0]        driverPowered,
    output logic              highADiagSourceOn,
    output logic              globalShutdownReq,
    output logic              interruptOut
);

    localparam int DRV  = `BDC_DRV_COUNT;
    localparam int LOWS = `BDC_LOW_COUNT;
    localparam int STEP = `BDC_DRV_STRIDE;

    fet_monitor_s monSync;
    fet_monitor_s monPrev;
    ctrl_t        ctrlReg;
    ctrl_t        ctrlNext;
    ctrl_t        ctrlRead;
    logic [1:0]   ocFlagReg;
    logic [1:0]   ocFlagNext;
    logic [1:0]   supplyError;
    logic [2:0]   killMask;
    logic         globalTrip;
    logic         ocGlobal;
    logic         ctrlWrite;
    irq_t         irqStatusReg;
    irq_t         irqEnableReg;
    irq_t         irqClear;
    irq_event_s   irqEvent;
    data_t        readValue;

    // every monitor pin passes two flops before anything reads it
    sync_flags #(
        .WIDTH ($bits(fet_monitor_s))
    ) uSync (
        .clk     (clk),
        .rstn    (rstn),
        .asyncIn (fetMonitor),
        .syncOut (monSync)
    );

    // previous synchronised sample, used only for edge events
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            monPrev <= '0;
        end else begin
            monPrev <= monSync;
        end
    end

    assign ctrlWrite = busWrite && (busAddr == `BDC_ADDR_CTRL);

    // supply error is a pure OR of the two supply monitors, no latching
    assign supplyError = monSync.drainSupplyStatus | monSync.chargePumpSupplyStatus;

    // shutdown decision; level based so a persisting fault keeps the gates off
    always_comb begin
        ocGlobal   = 1'b0;
        killMask   = 3'h0;
        for (int i = 0; i < LOWS; i++) begin
            if (monSync.overcurrent[i]) begin
                if (ctrlReg[i*STEP + `BDC_FLD_SHUT_SCOPE]) begin
                    killMask[i] = 1'b1;
                    // low_a shares bridge one with high_a
                    if (i == 0) begin
                        killMask[2] = 1'b1;
                    end
                end else begin
                    ocGlobal = 1'b1;
                end
            end
        end
        globalTrip = otherBridgeShutdown || ocGlobal;
        if (globalTrip) begin
            killMask = 3'h7;
        end
    end

    // next control value: software writes only the writable bits, then
    // hardware clears on and pwm of killed drivers; hardware wins the clash
    always_comb begin
        ctrlNext = ctrlReg;
        if (ctrlWrite) begin
            ctrlNext = (ctrlReg & ~`BDC_CTRL_WR_MASK)
                     | (busWrData[20:0] & `BDC_CTRL_WR_MASK);
        end
        for (int i = 0; i < DRV; i++) begin
            if (killMask[i]) begin
                ctrlNext[i*STEP + `BDC_FLD_SWITCH_ON]  = 1'b0;
                ctrlNext[i*STEP + `BDC_FLD_PWM_FOLLOW] = 1'b0;
            end
        end
    end

    // control register; the third reset class reloads the reset value
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrlReg <= `BDC_CTRL_RESET;
        end else if (resetClassThree) begin
            ctrlReg <= `BDC_CTRL_RESET;
        end else begin
            ctrlReg <= ctrlNext;
        end
    end

    // overcurrent flags: set by the fault, cleared when software re-arms the
    // switch with a write of its on bit; a fault in the same cycle wins
    always_comb begin
        ocFlagNext = ocFlagReg;
        for (int i = 0; i < LOWS; i++) begin
            if (monSync.overcurrent[i]) begin
                ocFlagNext[i] = 1'b1;
            end else if (ctrlWrite && busWrData[i*STEP + `BDC_FLD_SWITCH_ON]) begin
                ocFlagNext[i] = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ocFlagReg <= 2'h0;
        end else if (resetClassThree) begin
            ocFlagReg <= 2'h0;
        end else begin
            ocFlagReg <= ocFlagNext;
        end
    end

    // read view of the control word: stored bits plus live short and supply bits and the sticky overcurrent flags
    always_comb begin
        ctrlRead = ctrlReg & `BDC_CTRL_WR_MASK;
        for (int i = 0; i < DRV; i++) begin
            // short flag is raw; only meaningful once the diag source is on
            ctrlRead[i*STEP + `BDC_FLD_DRAIN_SHORT] = monSync.drainShort[i];
        end
        for (int i = 0; i < LOWS; i++) begin
            ctrlRead[i*STEP + `BDC_FLD_SUPPLY_ERR]  = supplyError[i];
            ctrlRead[i*STEP + `BDC_FLD_OVERCURRENT] = ocFlagReg[i];
        end
    end

    // per-driver gate and power outputs, registered so they never glitch
    for (genvar g = 0; g < DRV; g++) begin : gDriver
        localparam int BASE = g * STEP;
        logic drive;

        // pwm follow overrides the static on bit; a kill forces off at once
        assign drive = ctrlReg[BASE + `BDC_FLD_PWM_FOLLOW] ? monSync.pwmIn[g]
                       : ctrlReg[BASE + `BDC_FLD_SWITCH_ON];

        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                gateOn[g]        <= 1'b0;
                driverPowered[g] <= 1'b0;
            end else begin
                driverPowered[g] <= ctrlReg[BASE + `BDC_FLD_POWER_EN];
                gateOn[g]        <= ctrlReg[BASE + `BDC_FLD_POWER_EN] && !killMask[g]
                                    && drive;
            end
        end
    end

    // only the high-side driver has a real diagnosis current source
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            highADiagSourceOn <= 1'b0;
        end else begin
            highADiagSourceOn <= ctrlReg[2*STEP + `BDC_FLD_DIAG_SRC];
        end
    end

    // tells the other bridges to shut down; only our own global-scope fault asks,
    // an outside request is not echoed back so two bridges cannot latch each other
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            globalShutdownReq <= 1'b0;
        end else begin
            globalShutdownReq <= ocGlobal;
        end
    end

    // rising edges of the monitored conditions become interrupt events
    assign irqEvent.overcurrent = monSync.overcurrent & ~monPrev.overcurrent;
    assign irqEvent.supplyError = supplyError
                                & ~(monPrev.drainSupplyStatus | monPrev.chargePumpSupplyStatus);
    assign irqEvent.drainShort  = monSync.drainShort & ~monPrev.drainShort;

    assign irqClear = (busWrite && (busAddr == `BDC_ADDR_IRQ_CLEAR)) ? busWrData[6:0] : 7'h00;

    // sticky status: an event in the clearing cycle is kept
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irqStatusReg <= `BDC_IRQ_RESET;
        end else begin
            irqStatusReg <= (irqStatusReg & ~irqClear) | irqEvent;
        end
    end

    // interrupt enable register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irqEnableReg <= `BDC_IRQ_RESET;
        end else if (busWrite && (busAddr == `BDC_ADDR_IRQ_ENABLE)) begin
            irqEnableReg <= busWrData[6:0];
        end
    end

    // level interrupt, one cycle behind the status it reflects
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            interruptOut <= 1'b0;
        end else begin
            interruptOut <= |(irqStatusReg & irqEnableReg);
        end
    end

    // read decode; unmapped and write-only addresses read as zero
    always_comb begin
        case (busAddr)
            `BDC_ADDR_CTRL: begin
                readValue = {11'h000, ctrlRead};
            end
            `BDC_ADDR_IRQ_STATUS: begin
                readValue = {25'h0000000, irqStatusReg};
            end
            `BDC_ADDR_IRQ_ENABLE: begin
                readValue = {25'h0000000, irqEnableReg};
            end
            default: begin
                readValue = 32'h00000000;
            end
        endcase
    end

    // read data stand for exactly the cycle after the strobe
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            busRdData <= 32'h00000000;
        end else if (busRead) begin
            busRdData <= readValue;
        end else begin
            busRdData <= 32'h00000000;
        end
    end

endmodule // bridge_driver_control

// [bench/bdc_props.sv]
`timescale 1ns/1ps
`include "bridge_ctrl_regs.svh"

module bdc_props
    import bridge_ctrl_pkg::*;
(
    input wire logic         clk,
    input wire logic         rstn,
    input wire addr_t        busAddr,
    input wire data_t        busWrData,
    input wire logic         busWrite,
    input wire logic         busRead,
    input wire data_t        busRdData,
    input wire logic         resetClassThree,
    input wire logic         otherBridgeShutdown,
    input wire fet_monitor_s fetMonitor,
    input wire logic [2:0]   gateOn,
    input wire logic [2:0]   driverPowered,
    input wire logic         highADiagSourceOn,
    input wire logic         globalShutdownReq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    // software access to the control word
    sequence s_wr;
        busWrite && busAddr == `BDC_ADDR_CTRL && !resetClassThree;
    endsequence
    sequence s_rd;
        busRead && busAddr == `BDC_ADDR_CTRL;
    endsequence
    // pins quiet long enough to have crossed the synchroniser
    sequence s_calm;
        $stable(fetMonitor) [*5];
    endsequence

    property p_short;
        s_calm ##0 s_rd |=> {busRdData[20], busRdData[12], busRdData[4]}
            == $past(fetMonitor.drainShort);
    endproperty
    property p_supply;
        s_calm ##0 s_rd |=> {busRdData[13], busRdData[5]}
            == $past(fetMonitor.drainSupplyStatus | fetMonitor.chargePumpSupplyStatus);
    endproperty
    property p_diag;
        s_wr |-> ##2 highADiagSourceOn == $past(busWrData[19], 2);
    endproperty
    property p_power;
        s_wr |-> ##2 driverPowered
            == {$past(busWrData[16], 2), $past(busWrData[8], 2), $past(busWrData[0], 2)};
    endproperty
    property p_extKill;
        otherBridgeShutdown |=> gateOn == 3'h0;
    endproperty
    property p_global;
        globalShutdownReq |=> gateOn == 3'h0;
    endproperty
    property p_ocKill;
        fetMonitor.overcurrent[0] [*4] |-> ##2 !gateOn[0];
    endproperty
    property p_reload;
        resetClassThree |-> ##2 driverPowered == 3'h7 && gateOn == 3'h0;
    endproperty

    a_short: assert property (p_short)
        else $error("short flags wrong");
    a_supply: assert property (p_supply)
        else $error("supply flags wrong");
    a_diag: assert property (p_diag)
        else $error("diag source wrong");
    a_power: assert property (p_power)
        else $error("driver power wrong");
    a_extKill: assert property (p_extKill)
        else $error("external kill missed");
    a_global: assert property (p_global)
        else $error("global kill missed");
    a_ocKill: assert property (p_ocKill)
        else $error("overcurrent kill missed");
    a_reload: assert property (p_reload)
        else $error("class three reload wrong");
endmodule // bdc_props

// [bench/fet_model.sv]
`timescale 1ns/1ps

// external fets seen through their monitor pins, faults as the bench commands
module fet_model
    import bridge_ctrl_pkg::*;
(
    input  wire logic [2:0] gateOn,
    input  wire logic       highADiagSourceOn,
    input  wire logic [2:0] pwmCmd,
    input  wire logic [2:0] shortCmd,
    input  wire logic [1:0] ocCmd,
    input  wire logic [1:0] dsCmd,
    input  wire logic [1:0] cpCmd,
    output fet_monitor_s    fetMonitor
);
    // a short only shows while the fet is off and the test current flows
    assign fetMonitor.drainShort = shortCmd & ~gateOn & {3{highADiagSourceOn}};
    // comparators report plain levels, no latching on this side
    assign fetMonitor.pwmIn = pwmCmd;
    assign fetMonitor.overcurrent = ocCmd;
    assign fetMonitor.drainSupplyStatus = dsCmd;
    assign fetMonitor.chargePumpSupplyStatus = cpCmd;
endmodule // fet_model

// [bench/test_bridge_driver_control.sv]
`timescale 1ns/1ps
`include "bridge_ctrl_regs.svh"

module test_bridge_driver_control
    import bridge_ctrl_pkg::*;
;
    localparam addr_t CA = `BDC_ADDR_CTRL;
    logic         clk = 1'b0;
    logic         rstn = 1'b0;
    addr_t        busAddr = 8'h00;
    data_t        busWrData = 32'h0;
    logic         busWrite = 1'b0;
    logic         busRead = 1'b0;
    logic         resetClassThree = 1'b0;
    logic         otherBridgeShutdown = 1'b0;
    logic [2:0]   pwmCmd = 3'h0;
    logic [2:0]   shortCmd = 3'h0;
    logic [1:0]   ocCmd = 2'h0;
    logic [1:0]   dsCmd = 2'h0;
    logic [1:0]   cpCmd = 2'h0;
    data_t        busRdData;
    data_t        rdVal;
    fet_monitor_s fetMonitor;
    logic [2:0]   gateOn;
    logic [2:0]   driverPowered;
    logic         highADiagSourceOn;
    logic         globalShutdownReq;
    logic         interruptOut;
    int           err_total = 0;
    int           num_checks = 0;

    bridge_driver_control u_bridge_driver_control (
        .clk(clk), .rstn(rstn), .busAddr(busAddr), .busWrData(busWrData),
        .busWrite(busWrite), .busRead(busRead), .busRdData(busRdData),
        .resetClassThree(resetClassThree), .otherBridgeShutdown(otherBridgeShutdown),
        .fetMonitor(fetMonitor), .gateOn(gateOn), .driverPowered(driverPowered),
        .highADiagSourceOn(highADiagSourceOn), .globalShutdownReq(globalShutdownReq),
        .interruptOut(interruptOut));
    fet_model u_fet_model (
        .gateOn(gateOn), .highADiagSourceOn(highADiagSourceOn), .pwmCmd(pwmCmd),
        .shortCmd(shortCmd), .ocCmd(ocCmd), .dsCmd(dsCmd), .cpCmd(cpCmd),
        .fetMonitor(fetMonitor));

    // 25 MHz clock
    initial begin
        forever #20 clk = ~clk;
    end

    task automatic chk(input string what, input data_t seen, input data_t exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic print_verdict;
        if (err_total == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // land 1 ns past the last edge so registered outputs have settled
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(input addr_t a, input data_t d);
        @(posedge clk);
        busWrite <= 1'b1;
        busAddr <= a;
        busWrData <= d;
        @(posedge clk);
        busWrite <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rc(input addr_t a, input data_t exp, input string what);
        @(posedge clk);
        busRead <= 1'b1;
        busAddr <= a;
        @(posedge clk);
        busRead <= 1'b0;
        #1;
        chk(what, busRdData, exp);
    endtask

    // reset values and stray accesses
    task automatic t_reset;
        rc(CA, 32'h00010101, "ctrl reset");
        chk("powered", driverPowered, 32'h7);
        wr(8'h10, 32'hffffffff);
        rc(8'h10, 32'h0, "unmapped");
        rc(`BDC_ADDR_IRQ_CLEAR, 32'h0, "clear reg");
    endtask

    // status bits ignore writes, diag bits steer only the high side
    task automatic t_write;
        wr(CA, 32'hffffffff); // every driver enabled
        rc(CA, 32'h000f8f8f, "ro ignored");
        chk("diag on", highADiagSourceOn, 32'h1);
        wr(CA, 32'h00050d0d);
        tick(2);
        chk("low diag", highADiagSourceOn, 32'h0);
        chk("gate on", gateOn, 32'h7);
        wr(CA, 32'h00010101);
        tick(2);
        chk("gate off", gateOn, 32'h0);
    endtask

    // pwm inputs steer the gates only while following is enabled
    task automatic t_pwm;
        wr(CA, 32'h00030303);
        for (int i = 1; i < 8; i += 3) begin
            @(posedge clk);
            pwmCmd <= 3'(i);
            tick(6);
            chk("pwm follow", gateOn, 32'(i));
        end
        wr(CA, 32'h00010101);
        tick(2);
        chk("pwm ignored", gateOn, 32'h0);
        pwmCmd <= 3'h0;
        wr(CA, 32'h00040505);
        tick(2);
        chk("power", driverPowered, 32'h3);
        chk("unpowered gate", gateOn, 32'h3);
    endtask

    // short flags need the test current source
    task automatic t_short;
        shortCmd <= 3'h7;
        wr(CA, 32'h00010101);
        tick(6);
        rc(CA, 32'h00010101, "short hidden");
        wr(CA, 32'h00090101);
        tick(6);
        rc(CA, 32'h00191111, "short seen");
        shortCmd <= 3'h0;
        wr(CA, 32'h00010101);
        for (int i = 0; i < 16; i++) begin
            @(posedge clk);
            dsCmd <= 2'(i);
            cpCmd <= 2'(i >> 2);
            tick(6);
            rc(CA, 32'h00010101 | (32'(i[1] | i[3]) << 13) | (32'(i[0] | i[2]) << 5),
               "supply");
        end
        dsCmd <= 2'h0;
        cpCmd <= 2'h0;
    endtask

    // local then global overcurrent, with the interrupt on the way
    task automatic t_oc;
        wr(`BDC_ADDR_IRQ_CLEAR, 32'h7f);
        wr(CA, 32'h00058585);
        ocCmd <= 2'h1;
        tick(6);
        chk("local gate", gateOn, 32'h2);
        chk("no global", globalShutdownReq, 32'h0);
        rc(CA, 32'h000185c1, "local flag");
        rc(`BDC_ADDR_IRQ_STATUS, 32'h1, "irq status");
        wr(`BDC_ADDR_IRQ_ENABLE, 32'h1);
        tick(2);
        chk("irq on", interruptOut, 32'h1);
        wr(`BDC_ADDR_IRQ_ENABLE, 32'h0);
        tick(2);
        chk("irq masked", interruptOut, 32'h0);
        wr(`BDC_ADDR_IRQ_ENABLE, 32'h1);
        wr(`BDC_ADDR_IRQ_CLEAR, 32'h1);
        tick(2);
        chk("irq cleared", interruptOut, 32'h0);
        ocCmd <= 2'h0;
        tick(6);
        wr(CA, 32'h00058585);
        rc(CA, 32'h00058585, "flag cleared");
        wr(CA, 32'h00050505);
        ocCmd <= 2'h2;
        tick(6);
        chk("global gate", gateOn, 32'h0);
        chk("global req", globalShutdownReq, 32'h1);
        rc(CA, 32'h00014101, "global flag");
        ocCmd <= 2'h0;
    endtask

    // outside shutdown, then the third reset class reload
    task automatic t_ext;
        // let the last overcurrent leave the synchroniser before re-arming
        tick(6);
        wr(CA, 32'h00058d8d);
        tick(2);
        chk("ext ready", gateOn, 32'h7);
        otherBridgeShutdown <= 1'b1;
        tick(2);
        chk("ext kill", gateOn, 32'h0);
        chk("no echo", globalShutdownReq, 32'h0);
        otherBridgeShutdown <= 1'b0;
        resetClassThree <= 1'b1;
        @(posedge clk);
        resetClassThree <= 1'b0;
        tick(2);
        rc(CA, 32'h00010101, "reload");
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        t_reset;
        t_write;
        t_pwm;
        t_short;
        t_oc;
        t_ext;
        print_verdict;
    end

    // the tests need under two thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        print_verdict;
    end
endmodule // test_bridge_driver_control

bind bridge_driver_control bdc_props u_bdc_props (
    .clk(clk), .rstn(rstn), .busAddr(busAddr), .busWrData(busWrData),
    .busWrite(busWrite), .busRead(busRead), .busRdData(busRdData),
    .resetClassThree(resetClassThree), .otherBridgeShutdown(otherBridgeShutdown),
    .fetMonitor(fetMonitor), .gateOn(gateOn), .driverPowered(driverPowered),
    .highADiagSourceOn(highADiagSourceOn), .globalShutdownReq(globalShutdownReq));
